// *** src/gpcu_control.sv ***
// Purpose: upper half of the upstream general pin control word
// Assumes: Avalon-MM slave, one wait cycle per access
// Notes: pin 3 direction lives in the lower half, given here as an input
// Overview of operation
// [R01] control word only at upstream offset b8
// [R02] bit 16 reads pin 4 level, resets one
// [R03] bit 17 pin 4 direction, resets zero
// [R04] bit 18 pin 4 output level, resets zero
// [R05] bit 20 reads pin 5 level, resets one
// [R06] bit 21 pin 5 direction, resets zero
// [R07] bit 22 pin 5 output level, resets zero
// [R08] bit 24 reads pin 6 level, resets one
// [R09] bit 25 pin 6 direction, resets zero
// [R10] bit 26 pin 6 output level, resets zero
// [R11] bit 28 reads pin 7 level, resets one
// [R12] bit 29 pin 7 direction, resets zero
// [R13] bit 30 pin 7 output level, resets zero
// [R14] bit 14 pin 3 output level, resets zero
// [R15] bits 15,19,23,27,31 read zero, writes ignored
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module gpcu_control
    import gpcu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // port role
    input wire logic is_upstream,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // pin 3 direction from lower half
    input wire logic p3_dir,
    // pin_out and pin_oe_n are pins 3..7, bit 0 is pin 3; pin_in is pins 4..7, bit 0 is pin 4
    input wire logic [3:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe_n
);
    import gpcu_pkg::*;

    // ==========================================================
    // state
    gpcu_bus_state_t state;
    gpcu_bus_state_t next_state;
    logic [3:0] dir;
    logic [3:0] out_val;
    logic p3_out;
    logic [3:0] sampled;

    // ==========================================================
    // helpers
    function automatic int gpcu_pos(input int pin, input int field);
        gpcu_pos = GPCU_BIT_BASE + pin * GPCU_STRIDE + field;
    endfunction

    // ==========================================================
    // decode
    wire access = avs_read | avs_write;
    wire hit = is_upstream && (avs_address == GPCU_OFS_CONTROL); // [R01]
    wire do_write = avs_write && hit && (state == GPCU_IDLE);
    wire be_hi = avs_byteenable[1];
    wire be_top2 = avs_byteenable[2];
    wire be_top3 = avs_byteenable[3];

    // one wait state: request taken in idle, answered in done
    assign avs_waitrequest = access && (state == GPCU_IDLE);
    assign next_state = (access && state == GPCU_IDLE) ? GPCU_DONE : GPCU_IDLE;

    // ==========================================================
    // read word assembly; reserved bits stay zero
    logic [31:0] word;
    always_comb
    begin
        word = 32'h0000_0000; // [R15]
        word[GPCU_BIT_P3_OUT] = p3_out; // [R14]
        for (int p = 0; p < GPCU_NPINS; p++)
        begin
            word[gpcu_pos(p, GPCU_OFS_IN)] = sampled[p]; // [R02] [R05] [R08] [R11]
            word[gpcu_pos(p, GPCU_OFS_DIR)] = dir[p];
            word[gpcu_pos(p, GPCU_OFS_OUT)] = out_val[p];
        end
    end
    wire [31:0] next_readdata = hit ? word : GPCU_UNMAPPED_DATA;

    // ==========================================================
    // sampled inputs
    gpcu_pin_sample u_sample
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_level(pin_in),
        .sampled(sampled)
    );

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= GPCU_IDLE;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
            if (avs_read && state == GPCU_IDLE)
                avs_readdata <= next_readdata;
        end
    end

    // pins 4..7 byte lanes 2 and 3, pin 3 byte lane 1; writes take effect in idle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dir <= GPCU_RST_DIR; // [R03] [R06] [R09] [R12]
            out_val <= GPCU_RST_OUT; // [R04] [R07] [R10] [R13]
            p3_out <= GPCU_RST_P3_OUT; // [R14]
        end
        else if (do_write)
        begin
            if (be_hi)
                p3_out <= avs_writedata[GPCU_BIT_P3_OUT]; // [R14]
            if (be_top2)
            begin
                dir[1:0] <= {avs_writedata[21], avs_writedata[17]}; // [R03] [R06]
                out_val[1:0] <= {avs_writedata[22], avs_writedata[18]}; // [R04] [R07]
            end
            if (be_top3)
            begin
                dir[3:2] <= {avs_writedata[29], avs_writedata[25]}; // [R09] [R12]
                out_val[3:2] <= {avs_writedata[30], avs_writedata[26]}; // [R10] [R13]
            end
        end
    end

    // ==========================================================
    // pin drivers; pin 3 uses the lower-half direction bit
    gpcu_pin_drive u_drive
    (
        .dir({dir, p3_dir}),
        .out_val({out_val, p3_out}),
        .pin_out(pin_out),
        .pin_oe_n(pin_oe_n)
    );

    // ==========================================================
    // checks
    a_pin_dir_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pin_oe_n[4:1] == ~dir) else $error("pin enable not from direction"); // [R03]
    a_pin_drive_val: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !pin_oe_n[1] |-> pin_out[1] == out_val[0]) else $error("pin 4 level wrong"); // [R04]
    a_read_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (avs_readdata & 32'h8888_8000) == 32'h0000_0000)
        else $error("reserved bit set"); // [R15]
    a_input_sample: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 sampled == $past(pin_in)) else $error("input not sampled"); // [R02]
    a_offmap_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (avs_read && !avs_waitrequest && !$past(hit)) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero"); // [R01]
    a_write_dir_upd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (do_write && be_top3) |=> dir[3] == $past(avs_writedata[29]))
        else $error("pin 7 direction not written"); // [R12]
    a_write_out_upd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (do_write && be_top2) |=> out_val[1] == $past(avs_writedata[22]))
        else $error("pin 5 level not written"); // [R07]
    a_p3_out_upd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (do_write && be_hi) |=> pin_out[0] == $past(avs_writedata[14]))
        else $error("pin 3 level not written"); // [R14]
    a_no_write_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !do_write |=> $stable(dir) && $stable(out_val))
        else $error("control changed without write"); // [R10]
    a_wait_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (access && state == GPCU_IDLE) |=> !avs_waitrequest)
        else $error("answer not after one wait"); // [R01]

    c_read_hit: cover property (@(posedge clk_sys) avs_read && hit && !avs_waitrequest);
    c_write_hit: cover property (@(posedge clk_sys) do_write && be_top3);
    c_pin_driven: cover property (@(posedge clk_sys) !pin_oe_n[4] && pin_out[4]);
    c_unmapped: cover property (@(posedge clk_sys) avs_read && !hit && !avs_waitrequest);
endmodule

// *** shared/gpcu_pkg.sv ***
// Purpose: constants for the upper general pin control block
// Assumes: 32-bit Avalon-MM register port, word addressed by byte offset
// Notes: field positions are bit indices within the control word
package gpcu_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] GPCU_OFS_CONTROL = 8'hb8;
    localparam logic [7:0] GPCU_ADDR_W = 8'h08;
    // ==========================================================
    // field positions
    localparam int GPCU_BIT_P3_OUT = 14;
    localparam int GPCU_BIT_BASE = 16;
    localparam int GPCU_NPINS = 4;
    localparam int GPCU_STRIDE = 4;
    localparam int GPCU_OFS_IN = 0;
    localparam int GPCU_OFS_DIR = 1;
    localparam int GPCU_OFS_OUT = 2;
    // ==========================================================
    // reset values
    localparam logic [3:0] GPCU_RST_IN = 4'hf;
    localparam logic [3:0] GPCU_RST_DIR = 4'h0;
    localparam logic [3:0] GPCU_RST_OUT = 4'h0;
    localparam logic GPCU_RST_P3_OUT = 1'b0;
    localparam logic [31:0] GPCU_UNMAPPED_DATA = 32'h0000_0000;
    // ==========================================================
    // bus answer states
    typedef enum logic [0:0]
    {
        GPCU_IDLE = 1'b0,
        GPCU_DONE = 1'b1
    } gpcu_bus_state_t;
endpackage

// *** src/gpcu_pin_sample.sv ***
// Purpose: registers the live level of the upper pins
// Assumes: pins synchronous to clk_sys
// Notes: reads one after reset until the first edge
`timescale 1ns/1ps
module gpcu_pin_sample
    import gpcu_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pins
    input wire logic [3:0] pin_level,
    output logic [3:0] sampled
);
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sampled <= GPCU_RST_IN;
        else
            sampled <= pin_level;
    end
endmodule

// *** src/gpcu_pin_drive.sv ***
// Purpose: per-pin output driver for one two-way pin group
// Assumes: enable port low means the module drives the pin
// Notes: pure combinational
`timescale 1ns/1ps
module gpcu_pin_drive
(
    // control
    input wire logic [4:0] dir,
    input wire logic [4:0] out_val,
    // pins
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe_n
);
    assign pin_out = out_val;
    assign pin_oe_n = ~dir;
endmodule

// *** verification/gpcu_board_model.sv ***
// Purpose: board side of the upper general pins
// Assumes: the board lets go of a pin while the device drives it
// Notes: no pull on these lines, so a driven pin shows the device level
`timescale 1ns/1ps
module gpcu_board_model
(
    // from device
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe_n,
    // board stimulus
    input wire logic [3:0] board_level,
    // to device, bit 0 is pin 4
    output logic [3:0] pin_in
);
    // ============================================================
    // wire level
    assign pin_in = (~pin_oe_n[4:1] & pin_out[4:1]) | (pin_oe_n[4:1] & board_level);
endmodule

// *** verification/gpcu_control_tb_top.sv ***
// Purpose: self-checking bench for the upper general pin control word
// Assumes: one wait cycle per access, but the bus task never counts on it
// Notes: expected words are built from the package field positions
`timescale 1ns/1ps
module gpcu_control_tb_top;
    import gpcu_pkg::*;
    logic clk_sys, rst_n, is_upstream, avs_read, avs_write, avs_waitrequest, p3_dir;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable, pin_in, board_level;
    logic [4:0] pin_out, pin_oe_n;
    int err_count, num_checks;
    // ============================================================
    // design and board
    gpcu_control dut (.clk_sys(clk_sys), .rst_n(rst_n), .is_upstream(is_upstream),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .p3_dir(p3_dir),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    gpcu_board_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .board_level(board_level), .pin_in(pin_in));
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ============================================================
    // reporting and compares
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // pins move at the edge the write lands, so look a little later
    task automatic chk_pins(input logic [4:0] e_out, input logic [4:0] e_oe_n);
        #1;
        chk({27'h0, pin_out}, {27'h0, e_out});
        chk({27'h0, pin_oe_n}, {27'h0, e_oe_n});
    endtask
    function automatic logic [31:0] word(input logic [3:0] lv, input logic [3:0] dir,
        input logic [3:0] ov, input logic p3);
        logic [31:0] w;
        w = 32'h0;
        w[GPCU_BIT_P3_OUT] = p3;
        for (int i = 0; i < GPCU_NPINS; i++)
        begin
            w[GPCU_BIT_BASE + GPCU_STRIDE * i + GPCU_OFS_IN] = lv[i];
            w[GPCU_BIT_BASE + GPCU_STRIDE * i + GPCU_OFS_DIR] = dir[i];
            w[GPCU_BIT_BASE + GPCU_STRIDE * i + GPCU_OFS_OUT] = ov[i];
        end
        return w;
    endfunction
    // ============================================================
    // one bus transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        logic done;
        @(posedge clk_sys);
        avs_write <= wr;
        avs_read <= ~wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        done = 1'b0;
        while (!done)
        begin
            @(posedge clk_sys);
            done = (avs_waitrequest === 1'b0);
            rd = avs_readdata;
            n++;
            if (n > 20)
            begin
                err_count++;
                results();
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // ============================================================
    // scenarios
    task automatic sc_all_ones();
        p3_dir <= 1'b1;
        bus(1'b1, GPCU_OFS_CONTROL, 32'hffff_ffff, 4'hf);
        chk_pins(5'h1f, 5'h00);
        bus(1'b0, GPCU_OFS_CONTROL, 32'h0, 4'hf);
        chk(rd, word(4'hf, 4'hf, 4'hf, 1'b1));
    endtask
    task automatic sc_each_pin();
        p3_dir <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, GPCU_OFS_CONTROL, 32'h4000 | (32'h1 << (17 + 4 * i)), 4'hf);
            chk_pins(5'h01, {~(4'h1 << i), 1'b1});
            bus(1'b0, GPCU_OFS_CONTROL, 32'h0, 4'hf);
            chk(rd, word(~(4'h1 << i), 4'h1 << i, 4'h0, 1'b1));
        end
    endtask
    task automatic sc_lanes();
        bus(1'b1, GPCU_OFS_CONTROL, 32'h0, 4'hf);
        bus(1'b1, GPCU_OFS_CONTROL, 32'hffff_ffff, 4'h4);
        bus(1'b1, GPCU_OFS_CONTROL, 32'hffff_ffff, 4'h1);
        bus(1'b0, GPCU_OFS_CONTROL, 32'h0, 4'hf);
        chk(rd, word(4'hf, 4'h3, 4'h3, 1'b0));
    endtask
    task automatic sc_refuse();
        bus(1'b1, 8'hbc, 32'h0, 4'hf);
        bus(1'b0, 8'hbc, 32'h0, 4'hf);
        chk(rd, 32'h0);
        is_upstream <= 1'b0;
        bus(1'b1, GPCU_OFS_CONTROL, 32'h0, 4'hf);
        bus(1'b0, GPCU_OFS_CONTROL, 32'h0, 4'hf);
        chk(rd, 32'h0);
        is_upstream <= 1'b1;
        bus(1'b0, GPCU_OFS_CONTROL, 32'h0, 4'hf);
        chk(rd, word(4'hf, 4'h3, 4'h3, 1'b0));
    endtask
    task automatic sc_inputs();
        bus(1'b1, GPCU_OFS_CONTROL, 32'h0, 4'hf);
        board_level <= 4'ha;
        bus(1'b0, GPCU_OFS_CONTROL, 32'h0, 4'hf);
        chk(rd, word(4'ha, 4'h0, 4'h0, 1'b0));
    endtask
    // ============================================================
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        is_upstream = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        p3_dir = 1'b0;
        board_level = 4'hf;
        err_count = 0;
        num_checks = 0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_pins(5'h00, 5'h1f);
        bus(1'b0, GPCU_OFS_CONTROL, 32'h0, 4'hf);
        chk(rd, word(4'hf, 4'h0, 4'h0, 1'b0));
        sc_all_ones();
        sc_each_pin();
        sc_lanes();
        sc_refuse();
        sc_inputs();
        results();
    end
endmodule
